/* File: nibcpu_pkg.sv */
// Shared opcodes, reset values, states and carriers of the nibble processor.
package nibcpu_pkg;

	// Upper nibble of the instruction byte.
	localparam logic [3:0] OP_NOP                   = 4'h0;
	localparam logic [3:0] OP_CONDITIONAL_JUMP      = 4'h1;
	localparam logic [3:0] OP_PAIR_GROUP            = 4'h2;
	localparam logic [3:0] OP_INDIRECT_GROUP        = 4'h3;
	localparam logic [3:0] OP_JUMP_UNCONDITIONAL    = 4'h4;
	localparam logic [3:0] OP_CALL_SUBROUTINE       = 4'h5;
	localparam logic [3:0] OP_INCREMENT             = 4'h6;
	localparam logic [3:0] OP_INCREMENT_SKIP_ZERO   = 4'h7;
	localparam logic [3:0] OP_ADD_REG               = 4'h8;
	localparam logic [3:0] OP_SUB_REG               = 4'h9;
	localparam logic [3:0] OP_LOAD_REGISTER_TO_ACC  = 4'hA;
	localparam logic [3:0] OP_EXCHANGE              = 4'hB;
	localparam logic [3:0] OP_RETURN_AND_LOAD       = 4'hC;
	localparam logic [3:0] OP_LOAD_IMMEDIATE_ACC    = 4'hD;
	localparam logic [3:0] OP_IO_GROUP              = 4'hE;
	localparam logic [3:0] OP_ACC_GROUP             = 4'hF;

	// Lower nibble inside the memory and port group.
	localparam logic [3:0] IO_WRITE_RAM_CHAR           = 4'h0;
	localparam logic [3:0] IO_WRITE_RAM_PORT           = 4'h1;
	localparam logic [3:0] IO_WRITE_ROM_PORT           = 4'h2;
	localparam logic [3:0] IO_WRITE_PROGRAM_HALF_BYTE  = 4'h3;
	localparam logic [3:0] IO_SUBTRACT_RAM_CHAR        = 4'h8;
	localparam logic [3:0] IO_READ_RAM_CHAR            = 4'h9;
	localparam logic [3:0] IO_READ_ROM_PORT            = 4'hA;
	localparam logic [3:0] IO_ADD_RAM_CHAR             = 4'hB;

	// Lower nibble inside the accumulator group.
	localparam logic [3:0] ACC_CLEAR_ACC_AND_CARRY        = 4'h0;
	localparam logic [3:0] ACC_CLEAR_CARRY                = 4'h1;
	localparam logic [3:0] ACC_INCREMENT_ACC              = 4'h2;
	localparam logic [3:0] ACC_COMPLEMENT_CARRY           = 4'h3;
	localparam logic [3:0] ACC_COMPLEMENT_ACC             = 4'h4;
	localparam logic [3:0] ACC_ROTATE_LEFT_THROUGH_CARRY  = 4'h5;
	localparam logic [3:0] ACC_ROTATE_RIGHT_THROUGH_CARRY = 4'h6;
	localparam logic [3:0] ACC_TRANSMIT_CARRY             = 4'h7;
	localparam logic [3:0] ACC_DECREMENT_ACC              = 4'h8;
	localparam logic [3:0] ACC_CARRY_SUBTRACT_TRANSFER    = 4'h9;
	localparam logic [3:0] ACC_SET_CARRY                  = 4'hA;
	localparam logic [3:0] ACC_DECIMAL_ADJUST_ACC         = 4'hB;
	localparam logic [3:0] ACC_ONE_OF_FOUR                = 4'hC;
	localparam logic [3:0] ACC_DESIGNATE_COMMAND_LINE     = 4'hD;

	// Arithmetic constants.
	localparam logic [3:0] DAA_LIMIT         = 4'h9;
	localparam logic [3:0] DAA_OFFSET        = 4'h6;
	localparam logic [3:0] TCS_WITH_CARRY    = 4'hA;
	localparam logic [3:0] TCS_NO_CARRY      = 4'h9;
	localparam logic [3:0] ONE_OF_FOUR_BAD   = 4'hF;

	// Values after reset.
	localparam logic [11:0] PC_RESET       = 12'h000;
	localparam logic [3:0]  ACC_RESET      = 4'h0;
	localparam logic        CY_RESET       = 1'b0;
	localparam logic [3:0]  REG_RESET      = 4'h0;
	localparam logic [7:0]  SEL_RESET      = 8'h00;
	localparam logic [2:0]  CMD_LINE_RESET = 3'h0;
	localparam logic        TEST_RESET     = 1'b0;

	typedef enum logic [2:0] {
		ST_FETCH          = 3'b000,
		ST_FETCH_ARG      = 3'b001,
		ST_EXECUTE        = 3'b010,
		ST_FETCH_INDIRECT = 3'b011,
		ST_IO_WAIT        = 3'b100
	} nibcpu_state_t;

	// One command to the memory and port chips.
	typedef struct packed {
		logic       is_src;
		logic [3:0] op;
		logic [7:0] sel;
		logic [3:0] data;
	} nibcpu_io_req_t;

	function automatic logic is_two_word(input logic [7:0] ir);
		return ir[7:4] == OP_CONDITIONAL_JUMP ||
			(ir[7:4] == OP_PAIR_GROUP && !ir[0]) ||
			ir[7:4] == OP_JUMP_UNCONDITIONAL ||
			ir[7:4] == OP_CALL_SUBROUTINE ||
			ir[7:4] == OP_INCREMENT_SKIP_ZERO;
	endfunction

endpackage

/* File: nibcpu_regfile.sv */
// Sixteen four-bit index registers, addressable singly or as eight pairs.
module nibcpu_regfile #(
	parameter int NUM_REGS = 16
) (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	// Single register write
	input  wire logic       i_wr_en,
	input  wire logic [3:0] i_wr_idx,
	input  wire logic [3:0] i_wr_data,
	// Pair write, even register takes the high nibble
	input  wire logic       i_pw_en,
	input  wire logic [2:0] i_pw_idx,
	input  wire logic [7:0] i_pw_data,
	// Reads
	input  wire logic [3:0] i_rd_idx,
	output logic [3:0]      o_rd_data,
	input  wire logic [2:0] i_pr_idx,
	output logic [7:0]      o_pr_data,
	output logic [7:0]      o_pair0
);

	logic [3:0] regs_ff [NUM_REGS];

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_ff[i] <= nibcpu_pkg::REG_RESET;
			end
		end else if (i_pw_en) begin
			regs_ff[{i_pw_idx, 1'b0}] <= i_pw_data[7:4];
			regs_ff[{i_pw_idx, 1'b1}] <= i_pw_data[3:0];
		end else if (i_wr_en) begin
			regs_ff[i_wr_idx] <= i_wr_data;
		end
	end

	assign o_rd_data = regs_ff[i_rd_idx];
	assign o_pr_data = {regs_ff[{i_pr_idx, 1'b0}], regs_ff[{i_pr_idx, 1'b1}]};
	assign o_pair0   = {regs_ff[0], regs_ff[1]};

endmodule // nibcpu_regfile

/* File: nibcpu_alu.sv */
// Accumulator and carry arithmetic for register, memory and accumulator ops.
module nibcpu_alu (
	// Operation
	input  wire logic [3:0] i_opr,
	input  wire logic [3:0] i_opa,
	// Operands
	input  wire logic [3:0] i_acc,
	input  wire logic       i_cy,
	input  wire logic [3:0] i_operand,
	// Results
	output logic [3:0]      o_acc,
	output logic            o_cy
);

	function automatic logic [4:0] add4(input logic [3:0] a,
		input logic [3:0] b, input logic cin);
		return {1'b0, a} + {1'b0, b} + {4'h0, cin};
	endfunction

	// Carry in set means a borrow, so a cleared carry subtracts exactly.
	function automatic logic [4:0] sub4(input logic [3:0] a,
		input logic [3:0] b, input logic cin);
		return add4(a, ~b, ~cin);
	endfunction

	function automatic logic [3:0] one_of_four(input logic [3:0] a);
		unique case (a)
			4'h0: return 4'h0;
			4'h1: return 4'h1;
			4'h2: return 4'h2;
			4'h4: return 4'h3;
			4'h8: return 4'h4;
			default: return nibcpu_pkg::ONE_OF_FOUR_BAD;
		endcase
	endfunction

	always_comb begin
		logic [4:0] sum;
		sum   = 5'h00;
		o_acc = i_acc;
		o_cy  = i_cy;
		unique case (i_opr)
			nibcpu_pkg::OP_ADD_REG: begin
				sum = add4(i_acc, i_operand, i_cy);
				{o_cy, o_acc} = sum;
			end
			nibcpu_pkg::OP_SUB_REG: begin
				sum = sub4(i_acc, i_operand, i_cy);
				{o_cy, o_acc} = sum;
			end
			nibcpu_pkg::OP_LOAD_REGISTER_TO_ACC,
			nibcpu_pkg::OP_EXCHANGE,
			nibcpu_pkg::OP_RETURN_AND_LOAD,
			nibcpu_pkg::OP_LOAD_IMMEDIATE_ACC: begin
				o_acc = i_operand;
			end
			nibcpu_pkg::OP_IO_GROUP: begin
				if (i_opa == nibcpu_pkg::IO_SUBTRACT_RAM_CHAR) begin
					sum = sub4(i_acc, i_operand, i_cy);
					{o_cy, o_acc} = sum;
				end else if (i_opa == nibcpu_pkg::IO_ADD_RAM_CHAR) begin
					sum = add4(i_acc, i_operand, i_cy);
					{o_cy, o_acc} = sum;
				end else if (i_opa[3]) begin
					o_acc = i_operand;
				end
			end
			nibcpu_pkg::OP_ACC_GROUP: begin
				unique case (i_opa)
					nibcpu_pkg::ACC_CLEAR_ACC_AND_CARRY: begin
						o_acc = 4'h0;
						o_cy  = 1'b0;
					end
					nibcpu_pkg::ACC_CLEAR_CARRY: o_cy = 1'b0;
					nibcpu_pkg::ACC_INCREMENT_ACC: begin
						sum = add4(i_acc, 4'h1, 1'b0);
						{o_cy, o_acc} = sum;
					end
					nibcpu_pkg::ACC_COMPLEMENT_CARRY: o_cy = ~i_cy;
					nibcpu_pkg::ACC_COMPLEMENT_ACC: o_acc = ~i_acc;
					nibcpu_pkg::ACC_ROTATE_LEFT_THROUGH_CARRY:
						{o_cy, o_acc} = {i_acc, i_cy};
					nibcpu_pkg::ACC_ROTATE_RIGHT_THROUGH_CARRY:
						{o_acc, o_cy} = {i_cy, i_acc};
					nibcpu_pkg::ACC_TRANSMIT_CARRY: begin
						o_acc = {3'h0, i_cy};
						o_cy  = 1'b0;
					end
					nibcpu_pkg::ACC_DECREMENT_ACC: begin
						sum = add4(i_acc, 4'hF, 1'b0);
						{o_cy, o_acc} = sum;
					end
					nibcpu_pkg::ACC_CARRY_SUBTRACT_TRANSFER: begin
						o_acc = i_cy ? nibcpu_pkg::TCS_WITH_CARRY
							: nibcpu_pkg::TCS_NO_CARRY;
						o_cy  = 1'b0;
					end
					nibcpu_pkg::ACC_SET_CARRY: o_cy = 1'b1;
					nibcpu_pkg::ACC_DECIMAL_ADJUST_ACC: begin
						if (i_acc > nibcpu_pkg::DAA_LIMIT || i_cy) begin
							sum   = add4(i_acc, nibcpu_pkg::DAA_OFFSET, 1'b0);
							o_acc = sum[3:0];
							o_cy  = i_cy | sum[4];
						end
					end
					nibcpu_pkg::ACC_ONE_OF_FOUR: o_acc = one_of_four(i_acc);
					default: ;
				endcase
			end
			default: ;
		endcase
	end

endmodule // nibcpu_alu

/* File: nibcpu_core.sv */
// Decode and execute core of the four-bit processor.
module nibcpu_core #(
	parameter int STACK_DEPTH = 3
) (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rstn,
	// Program memory fetch
	output logic                       o_rom_req,
	output logic [11:0]                o_rom_addr,
	input  wire logic                  i_rom_valid,
	input  wire logic [7:0]            i_rom_data,
	// Memory and port chip commands
	output logic                       o_io_valid,
	output nibcpu_pkg::nibcpu_io_req_t o_io_req,
	input  wire logic                  i_io_ack,
	input  wire logic [3:0]            i_io_data,
	// Test pin and command line
	input  wire logic                  i_test,
	output logic [2:0]                 o_cmd_line
);

	localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	nibcpu_pkg::nibcpu_state_t  state_ff;
	nibcpu_pkg::nibcpu_state_t  nxt_state;
	nibcpu_pkg::nibcpu_io_req_t io_req_ff;
	logic [11:0] pc_ff;
	logic [7:0]  ir_ff;
	logic [7:0]  arg_ff;
	logic [3:0]  acc_ff;
	logic        cy_ff;
	logic [11:0] stack_ff [STACK_DEPTH];
	logic [SPW-1:0] sp_ff;
	logic [SPW-1:0] sp_inc;
	logic [SPW-1:0] sp_dec;
	logic [7:0]  last_src_ff;
	logic [2:0]  cmd_line_ff;
	logic        test_s1_ff;
	logic        test_s2_ff;
	logic        test_s3_ff;
	logic        test_lvl_ff;
	logic [3:0]  opcode_upper_nibble;
	logic [3:0]  operand_lower_nibble;
	logic        in_exec;
	logic        jcn_take;
	logic [3:0]  rd_data;
	logic [7:0]  pr_data;
	logic [7:0]  pair0;
	logic [3:0]  inc_val;
	logic        wr_en;
	logic [3:0]  wr_data;
	logic        pw_en;
	logic [7:0]  pw_data;
	logic        alu_en;
	logic [3:0]  alu_opr;
	logic [3:0]  alu_opa;
	logic [3:0]  alu_operand;
	logic [3:0]  alu_acc;
	logic        alu_cy;

	assign opcode_upper_nibble     = ir_ff[7:4];
	assign operand_lower_nibble     = ir_ff[3:0];
	assign in_exec = (state_ff == nibcpu_pkg::ST_EXECUTE);
	assign inc_val = rd_data + 4'h1;
	assign sp_inc  = (sp_ff == SPW'(STACK_DEPTH - 1)) ? '0 : sp_ff + 1'b1;
	assign sp_dec  = (sp_ff == '0) ? SPW'(STACK_DEPTH - 1) : sp_ff - 1'b1;

	// The test pin is asynchronous; a level counts once two stages agree.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			test_s1_ff  <= nibcpu_pkg::TEST_RESET;
			test_s2_ff  <= nibcpu_pkg::TEST_RESET;
			test_s3_ff  <= nibcpu_pkg::TEST_RESET;
			test_lvl_ff <= nibcpu_pkg::TEST_RESET;
		end else begin
			test_s1_ff <= i_test;
			test_s2_ff <= test_s1_ff;
			test_s3_ff <= test_s2_ff;
			if (test_s2_ff == test_s3_ff) begin
				test_lvl_ff <= test_s3_ff;
			end
		end
	end

	// Opa bit 3 inverts; bits 2..0 pick zero acc, carry, test low.
	assign jcn_take = operand_lower_nibble[3] ^ ((operand_lower_nibble[2] && acc_ff == 4'h0) ||
		(operand_lower_nibble[1] && cy_ff) || (operand_lower_nibble[0] && !test_lvl_ff));

	nibcpu_regfile #(
		.NUM_REGS (16)
	) u_regs (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_wr_en   (wr_en),
		.i_wr_idx  (operand_lower_nibble),
		.i_wr_data (wr_data),
		.i_pw_en   (pw_en),
		.i_pw_idx  (operand_lower_nibble[3:1]),
		.i_pw_data (pw_data),
		.i_rd_idx  (operand_lower_nibble),
		.o_rd_data (rd_data),
		.i_pr_idx  (operand_lower_nibble[3:1]),
		.o_pr_data (pr_data),
		.o_pair0   (pair0)
	);

	// Register increments never touch carry; exchange stores the old accumulator.
	assign wr_en = in_exec && (opcode_upper_nibble == nibcpu_pkg::OP_INCREMENT ||
		opcode_upper_nibble == nibcpu_pkg::OP_INCREMENT_SKIP_ZERO ||
		opcode_upper_nibble == nibcpu_pkg::OP_EXCHANGE);
	assign wr_data = (opcode_upper_nibble == nibcpu_pkg::OP_EXCHANGE) ? acc_ff : inc_val;
	assign pw_en = (in_exec && opcode_upper_nibble == nibcpu_pkg::OP_PAIR_GROUP && !operand_lower_nibble[0]) ||
		(state_ff == nibcpu_pkg::ST_FETCH_INDIRECT && i_rom_valid);
	assign pw_data = (state_ff == nibcpu_pkg::ST_FETCH_INDIRECT) ?
		i_rom_data : arg_ff;

	// Reads from the memory chips reuse the memory group arithmetic.
	always_comb begin
		if (state_ff == nibcpu_pkg::ST_IO_WAIT) begin
			alu_opr     = nibcpu_pkg::OP_IO_GROUP;
			alu_opa     = io_req_ff.op;
			alu_operand = i_io_data;
		end else begin
			alu_opr     = opcode_upper_nibble;
			alu_opa     = operand_lower_nibble;
			alu_operand = (opcode_upper_nibble[3:2] == 2'b10) ? rd_data : operand_lower_nibble;
		end
	end

	assign alu_en = (in_exec && opcode_upper_nibble[3] && opcode_upper_nibble != nibcpu_pkg::OP_IO_GROUP) ||
		(state_ff == nibcpu_pkg::ST_IO_WAIT && i_io_ack &&
		!io_req_ff.is_src && io_req_ff.op[3]);

	nibcpu_alu u_alu (
		.i_opr     (alu_opr),
		.i_opa     (alu_opa),
		.i_acc     (acc_ff),
		.i_cy      (cy_ff),
		.i_operand (alu_operand),
		.o_acc     (alu_acc),
		.o_cy      (alu_cy)
	);

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			acc_ff <= nibcpu_pkg::ACC_RESET;
			cy_ff  <= nibcpu_pkg::CY_RESET;
		end else if (alu_en) begin
			acc_ff <= alu_acc;
			cy_ff  <= alu_cy;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			nibcpu_pkg::ST_FETCH: begin
				if (i_rom_valid) begin
					nxt_state = nibcpu_pkg::is_two_word(i_rom_data) ?
						nibcpu_pkg::ST_FETCH_ARG : nibcpu_pkg::ST_EXECUTE;
				end
			end
			nibcpu_pkg::ST_FETCH_ARG: begin
				if (i_rom_valid) begin
					nxt_state = nibcpu_pkg::ST_EXECUTE;
				end
			end
			nibcpu_pkg::ST_EXECUTE: begin
				if (opcode_upper_nibble == nibcpu_pkg::OP_INDIRECT_GROUP && !operand_lower_nibble[0]) begin
					nxt_state = nibcpu_pkg::ST_FETCH_INDIRECT;
				end else if (opcode_upper_nibble == nibcpu_pkg::OP_IO_GROUP ||
					(opcode_upper_nibble == nibcpu_pkg::OP_PAIR_GROUP && operand_lower_nibble[0])) begin
					nxt_state = nibcpu_pkg::ST_IO_WAIT;
				end else begin
					nxt_state = nibcpu_pkg::ST_FETCH;
				end
			end
			nibcpu_pkg::ST_FETCH_INDIRECT: begin
				if (i_rom_valid) begin
					nxt_state = nibcpu_pkg::ST_FETCH;
				end
			end
			nibcpu_pkg::ST_IO_WAIT: begin
				if (i_io_ack) begin
					nxt_state = nibcpu_pkg::ST_FETCH;
				end
			end
			default: nxt_state = nibcpu_pkg::ST_FETCH;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= nibcpu_pkg::ST_FETCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ir_ff  <= 8'h00;
			arg_ff <= 8'h00;
		end else if (i_rom_valid) begin
			if (state_ff == nibcpu_pkg::ST_FETCH) begin
				ir_ff <= i_rom_data;
			end else if (state_ff == nibcpu_pkg::ST_FETCH_ARG) begin
				arg_ff <= i_rom_data;
			end
		end
	end

	// The page of a short jump is that of the byte after the instruction.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pc_ff <= nibcpu_pkg::PC_RESET;
		end else if (i_rom_valid && (state_ff == nibcpu_pkg::ST_FETCH ||
			state_ff == nibcpu_pkg::ST_FETCH_ARG)) begin
			pc_ff <= pc_ff + 12'h001;
		end else if (in_exec) begin
			unique case (opcode_upper_nibble)
				nibcpu_pkg::OP_CONDITIONAL_JUMP: begin
					if (jcn_take) begin
						pc_ff <= {pc_ff[11:8], arg_ff};
					end
				end
				nibcpu_pkg::OP_INDIRECT_GROUP: begin
					if (operand_lower_nibble[0]) begin
						pc_ff <= {pc_ff[11:8], pr_data};
					end
				end
				nibcpu_pkg::OP_JUMP_UNCONDITIONAL,
				nibcpu_pkg::OP_CALL_SUBROUTINE:
					pc_ff <= {operand_lower_nibble, arg_ff};
				nibcpu_pkg::OP_INCREMENT_SKIP_ZERO: begin
					if (inc_val != 4'h0) begin
						pc_ff <= {pc_ff[11:8], arg_ff};
					end
				end
				nibcpu_pkg::OP_RETURN_AND_LOAD:
					pc_ff <= stack_ff[sp_dec];
				default: ;
			endcase
		end
	end

	// The stack wraps silently; a deeper call overwrites the oldest entry.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sp_ff <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_ff[i] <= nibcpu_pkg::PC_RESET;
			end
		end else if (in_exec && opcode_upper_nibble == nibcpu_pkg::OP_CALL_SUBROUTINE) begin
			stack_ff[sp_ff] <= pc_ff;
			sp_ff           <= sp_inc;
		end else if (in_exec && opcode_upper_nibble == nibcpu_pkg::OP_RETURN_AND_LOAD) begin
			sp_ff <= sp_dec;
		end
	end

	// The chips keep their own selection; the copy here tags each command.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			last_src_ff <= nibcpu_pkg::SEL_RESET;
			io_req_ff   <= '0;
		end else if (in_exec) begin
			if (opcode_upper_nibble == nibcpu_pkg::OP_PAIR_GROUP && operand_lower_nibble[0]) begin
				last_src_ff    <= pr_data;
				io_req_ff.is_src <= 1'b1;
				io_req_ff.op   <= operand_lower_nibble;
				io_req_ff.sel  <= pr_data;
				io_req_ff.data <= acc_ff;
			end else if (opcode_upper_nibble == nibcpu_pkg::OP_IO_GROUP) begin
				io_req_ff.is_src <= 1'b0;
				io_req_ff.op   <= operand_lower_nibble;
				io_req_ff.sel  <= last_src_ff;
				io_req_ff.data <= acc_ff;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cmd_line_ff <= nibcpu_pkg::CMD_LINE_RESET;
		end else if (in_exec && opcode_upper_nibble == nibcpu_pkg::OP_ACC_GROUP &&
			operand_lower_nibble == nibcpu_pkg::ACC_DESIGNATE_COMMAND_LINE) begin
			cmd_line_ff <= acc_ff[2:0];
		end
	end

	assign o_rom_req  = (state_ff == nibcpu_pkg::ST_FETCH) ||
		(state_ff == nibcpu_pkg::ST_FETCH_ARG) ||
		(state_ff == nibcpu_pkg::ST_FETCH_INDIRECT);
	assign o_rom_addr = (state_ff == nibcpu_pkg::ST_FETCH_INDIRECT) ?
		{pc_ff[11:8], pair0} : pc_ff;
	assign o_io_valid = (state_ff == nibcpu_pkg::ST_IO_WAIT);
	assign o_io_req   = io_req_ff;
	assign o_cmd_line = cmd_line_ff;

	chk_two_word_fetch: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(state_ff == nibcpu_pkg::ST_FETCH && i_rom_valid &&
		nibcpu_pkg::is_two_word(i_rom_data)) |=>
		state_ff == nibcpu_pkg::ST_FETCH_ARG && o_rom_addr == $past(pc_ff) + 12'h001)
		else $error("Two-word opcode did not fetch its next byte.");

	chk_cond_jump_page: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_CONDITIONAL_JUMP && jcn_take) |=>
		pc_ff == {$past(pc_ff[11:8]), $past(arg_ff)})
		else $error("Taken conditional jump landed at a wrong address.");

	chk_cond_jump_skip: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_CONDITIONAL_JUMP &&
		operand_lower_nibble == 4'h4 && acc_ff != 4'h0) |=> $stable(pc_ff))
		else $error("Conditional jump taken on a nonzero accumulator.");

	chk_src_emit_pair: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_PAIR_GROUP && operand_lower_nibble[0]) |=>
		o_io_valid && o_io_req.is_src && o_io_req.sel == $past(pr_data))
		else $error("Selection command did not carry the pair address.");

	chk_fetch_ind_addr: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_INDIRECT_GROUP && !operand_lower_nibble[0]) |=>
		o_rom_req && o_rom_addr == {pc_ff[11:8], $past(pair0)})
		else $error("Indirect fetch did not address through pair zero.");

	chk_jump_far_addr: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_JUMP_UNCONDITIONAL) |=>
		o_rom_req && o_rom_addr == {$past(operand_lower_nibble), $past(arg_ff)})
		else $error("Unconditional jump went to a wrong address.");

	chk_call_push_ret: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_CALL_SUBROUTINE) |=>
		stack_ff[$past(sp_ff)] == $past(pc_ff) && sp_ff == $past(sp_inc))
		else $error("Call did not save the return address.");

	chk_isz_zero_skip: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_INCREMENT_SKIP_ZERO &&
		rd_data == 4'hF) |=> $stable(pc_ff) && rd_data == 4'h0)
		else $error("Increment-skip jumped on a zero result.");

	chk_return_load: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		(in_exec && opcode_upper_nibble == nibcpu_pkg::OP_RETURN_AND_LOAD) |=>
		acc_ff == $past(operand_lower_nibble) && pc_ff == $past(stack_ff[sp_dec]))
		else $error("Return did not restore the address and data.");

	chk_io_selection: assert property (@(posedge i_sys_clk)
		disable iff (!i_rstn)
		$rose(o_io_valid) && !o_io_req.is_src |->
		o_io_req.sel == last_src_ff && o_io_req.data == acc_ff)
		else $error("Memory command lost the last selection.");

endmodule // nibcpu_core

/* File: nibcpu_mem_model.sv */
// Behavioural program and data memory chips facing the core.
module nibcpu_mem_model #(
	parameter logic [3:0] ROM_IN = 4'hC
) (
	// Clock
	input  wire logic                       i_sys_clk,
	// Program fetch
	input  wire logic                       i_rom_req,
	input  wire logic [11:0]                i_rom_addr,
	output logic                            o_rom_valid,
	output logic [7:0]                      o_rom_data,
	// Memory and port commands
	input  wire logic                       i_io_valid,
	input  wire nibcpu_pkg::nibcpu_io_req_t i_io_req,
	output logic                            o_io_ack,
	output logic [3:0]                      o_io_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rom [4096];
	logic [3:0] main_ch [256];
	logic [3:0] stat_ch [64];
	logic [7:0] sel = 8'h00;
	logic [3:0] wlog [$];
	logic [5:0] sidx;
	logic       take;
	initial begin
		o_io_ack = 1'b0;
		o_io_data = 4'h0;
		foreach (rom[a])
			rom[a] = 8'h00;
	end
	assign sidx = {sel[7:4], i_io_req.op[1:0]};
	assign take = i_io_valid && !o_io_ack;
	assign o_rom_valid = i_rom_req;
	// Outside a fetch the data lines carry the inverted byte so a stale byte is never taken.
	assign o_rom_data = i_rom_req ? rom[i_rom_addr] : ~rom[i_rom_addr];
	always @(posedge i_sys_clk) begin
		o_io_ack <= take;
		o_io_data <= ~o_io_data;
		if (take && i_io_req.is_src)
			sel <= i_io_req.sel;
		else if (take && !i_io_req.op[3]) begin
			wlog.push_back(i_io_req.data);
			if (i_io_req.op == 4'h0)
				main_ch[sel] <= i_io_req.data;
			if (i_io_req.op[2])
				stat_ch[sidx] <= i_io_req.data;
		end else if (take)
			o_io_data <= i_io_req.op[2] ? stat_ch[sidx] :
				(i_io_req.op[1:0] == 2'h2 ? ROM_IN : main_ch[sel]);
	end
endmodule // nibcpu_mem_model

/* File: tb.sv */
// Self-checking bench running short programs on the core.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       i_sys_clk, i_rstn, i_test;
	logic                       rom_req, rom_valid, io_valid, io_ack;
	logic [11:0]                rom_addr;
	logic [7:0]                 rom_data;
	logic [3:0]                 io_data;
	logic [2:0]                 cmd_line;
	nibcpu_pkg::nibcpu_io_req_t io_req;
	int                         fail_count = 0;
	int                         tests_run = 0;
	int                         cyc = 0;
	nibcpu_core uut (.i_sys_clk, .i_rstn, .o_rom_req(rom_req),
		.o_rom_addr(rom_addr), .i_rom_valid(rom_valid),
		.i_rom_data(rom_data), .o_io_valid(io_valid), .o_io_req(io_req),
		.i_io_ack(io_ack), .i_io_data(io_data), .i_test,
		.o_cmd_line(cmd_line));
	nibcpu_mem_model mem (.i_sys_clk, .i_rom_req(rom_req),
		.i_rom_addr(rom_addr), .o_rom_valid(rom_valid),
		.o_rom_data(rom_data), .i_io_valid(io_valid), .i_io_req(io_req),
		.o_io_ack(io_ack), .o_io_data(io_data));
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	task automatic final_report();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic check4(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic load(input logic [11:0] a, input logic [255:0] p,
		input int n);
		for (int i = 0; i < n; i++)
			mem.rom[a + 12'(i)] = p[8 * (n - 1 - i) +: 8];
	endtask
	// Each program gets a fresh reset; writes are logged by the model.
	task automatic run(input logic [63:0] e, input int n);
		i_rstn <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		mem.wlog.delete();
		i_rstn <= 1'b1;
		repeat (400) @(posedge i_sys_clk);
		check4(4'(mem.wlog.size()), 4'(n));
		for (int i = 0; i < n; i++)
			check4(mem.wlog[i], e[4 * (n - 1 - i) +: 4]);
		foreach (mem.rom[a])
			mem.rom[a] = 8'h00;
	endtask
	task automatic t_acc();
		load(12'h000, 104'hD9FAFBE0F1F4F8E0F6E0F5E0F3, 13);
		load(12'h00D, 104'hF7E0F9E0D8FCE0D3FCE0F0F2E0, 13);
		run(64'hFF7F194F1, 9);
	endtask
	task automatic t_regs();
		load(12'h000, 120'h2437A5E0F184E0F194E066B6E0A6E0, 15);
		run(64'h7A717, 5);
	endtask
	task automatic t_jump();
		load(12'h000, 16'h4010, 2);
		load(12'h010, 40'hF11A20D1E0, 5);
		load(12'h020, 56'hD2E0FA1230D3E0, 7);
		load(12'h030, 48'hD4E01140D5E0, 6);
		load(12'h040, 16'hD6E0, 2);
		run(64'h246, 3);
	endtask
	task automatic t_call();
		load(12'h000, 64'h5020E0224033D1E0, 8);
		load(12'h020, 8'hC3, 1);
		load(12'h040, 16'hD8E0, 2);
		run(64'h38, 2);
	endtask
	task automatic t_ram();
		load(12'h000, 72'h223523D7E0D9E5D0E9, 9);
		load(12'h009, 72'hE1EDE2F1D1EBE0EAE3, 9);
		run(64'h79798C, 6);
		check4(mem.main_ch[8'h35], 4'h8);
	endtask
	task automatic t_skip();
		load(12'h000, 88'h200EF27102E034A4E0D5FD, 11);
		run(64'h22, 2);
		check4({1'b0, cmd_line}, 4'h5);
	endtask
	// Far jump into page one, status slots 0, 2 and 3, borrow, test pin held high.
	task automatic t_more();
		load(12'h000, 16'h4100, 2);
		load(12'h100, 136'h223523D4E4D6E6D7E7D9E0EEE1ECE8E1EF, 17);
		load(12'h111, 56'h14201120E11920, 7);
		load(12'h120, 40'hDAE1FBF7E1, 5);
		i_test <= 1'b1;
		run(64'h46796B7A1, 9);
		i_test <= 1'b0;
	endtask
	initial begin
		i_rstn = 1'b0;
		i_test = 1'b0;
		t_acc();
		t_regs();
		t_jump();
		t_call();
		t_ram();
		t_skip();
		t_more();
		final_report();
	end
endmodule // tb
